// ===== logic/pirqfe_pkg.sv
package pirqfe_pkg;

    // Register byte addresses
    localparam logic [7:0] FLAGS_A_ADDR = 8'h00;
    localparam logic [7:0] FLAGS_B_ADDR = 8'h04;
    localparam logic [7:0] ENABLES_A_ADDR = 8'h08;
    localparam logic [7:0] ENABLES_B_ADDR = 8'h0c;
    localparam logic [7:0] GATE_CTRL_ADDR = 8'h10;
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'h14;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h18;

    // Field layout of gate control
    localparam int GATE_GLOBAL_BIT = 0;
    localparam int GATE_PERIPH_BIT = 1;
    localparam int GATE_PRIO_BIT = 2;

    // Flags that software may not clear (serial receive and transmit)
    localparam logic [7:0] FLAGS_A_HW_ONLY = 8'h30;
    // Implemented bits of the second flag and enable registers
    localparam logic [7:0] FLAGS_B_IMPL = 8'h1f;
    localparam logic [7:0] ENABLES_B_IMPL = 8'h1f;

    // Reset values
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] ENABLES_RESET = 8'h00;
    localparam logic [2:0] GATE_RESET = 3'h0;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // Summary interrupt status bits
    localparam int IRQ_STAT_REQ_BIT = 0;
    localparam int IRQ_STAT_CORE_BIT = 1;

    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage : pirqfe_pkg

// ===== logic/pirqfe_flag_cell.sv
`timescale 1ns/1ns
`default_nettype none
module pirqfe_flag_cell
    import pirqfe_pkg::*;
(
    input wire logic flag,
    input wire logic enable,
    input wire logic event_in,
    input wire logic clearReq,
    output logic next_flag,
    output logic pass
);
    always_comb begin
        // Event wins over a same-cycle clear
        next_flag = event_in | (flag & ~clearReq);
        pass = flag & enable;
    end
endmodule : pirqfe_flag_cell
`default_nettype wire

// ===== logic/pirqfe_periph_irq.sv
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Each flag except the two serial flags latches on its source event regardless of enables or gates; the serial flags follow their levels.
// - Flags live in two separate eight-bit flag registers, one bit per source.
// - Each source has its own enable bit in two separate enable registers.
// - With priority mode off, the peripheral gate must be one to pass requests to coreRequest.
// - Enable one passes the source request, enable zero blocks it.
// - Capture/compare A enable zero blocks its request; its flag still latches.
// - The priority mode bit is held outside this block's own flag logic.
module pirqfe_periph_irq
    import pirqfe_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] eventsA,
    input wire logic [7:0] eventsB,
    input wire logic priorityModeIn,
    input wire logic rxBufferFull,
    input wire logic txBufferEmpty,
    output logic periphRequest,
    output logic coreRequest,
    output logic irq
);

    typedef struct packed {
        logic [7:0] flagsA;
        logic [7:0] flagsB;
        logic [7:0] enablesA;
        logic [7:0] enablesB;
        logic globalGate;
        logic periphGate;
        logic prioMode;
        logic [1:0] irqStatus;
        logic [1:0] irqMask;
        logic [31:0] rdata;
        logic errFlag;
    } pirqfe_state_t;

    pirqfe_state_t st;
    pirqfe_state_t next_st;

    logic setup;
    logic access;
    logic wrAccess;
    logic rdAccess;
    logic hit;
    logic [15:0] allFlags;
    logic [15:0] allEnables;
    logic [15:0] allEvents;
    logic [15:0] allClears;
    logic [15:0] next_allFlags;
    logic [15:0] passBits;
    logic [7:0] wrByte;
    logic reqAny;
    logic coreAny;

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wrAccess = access & pwrite;
    assign rdAccess = setup & ~pwrite;
    assign wrByte = pwdata[7:0];

    always_comb begin
        case (paddr)
            FLAGS_A_ADDR, FLAGS_B_ADDR, ENABLES_A_ADDR, ENABLES_B_ADDR,
            GATE_CTRL_ADDR, IRQ_STATUS_ADDR, IRQ_MASK_ADDR: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // Serial flags track buffer state and ignore software clears
    assign allEvents = {eventsB & FLAGS_B_IMPL,
                        (eventsA & ~FLAGS_A_HW_ONLY)
                        | {2'b00, rxBufferFull, txBufferEmpty, 4'h0}};
    // Serial flags are cleared every cycle so that they follow their levels
    assign allClears = {(wrAccess && paddr == FLAGS_B_ADDR) ? ~wrByte : 8'h00,
                        ((wrAccess && paddr == FLAGS_A_ADDR) ? ~wrByte : 8'h00)
                        | FLAGS_A_HW_ONLY};
    assign allFlags = {st.flagsB, st.flagsA};
    assign allEnables = {st.enablesB, st.enablesA};

    // One cell per source; bit 2 is capture/compare A, bit 1 timer B match
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_src
            pirqfe_flag_cell u_cell (
                .flag(allFlags[gi]),
                .enable(allEnables[gi]),
                .event_in(allEvents[gi]),
                .clearReq(allClears[gi]),
                .next_flag(next_allFlags[gi]),
                .pass(passBits[gi])
            );
        end
    endgenerate

    assign reqAny = |passBits;
    // Priority mode on bypasses the peripheral gate; the global gate still applies
    assign coreAny = reqAny & st.globalGate
                     & (st.periphGate | st.prioMode);

    always_comb begin
        next_st = st;
        next_st.flagsA = next_allFlags[7:0];
        next_st.flagsB = next_allFlags[15:8] & FLAGS_B_IMPL;
        next_st.prioMode = priorityModeIn;
        if (wrAccess) begin
            case (paddr)
                ENABLES_A_ADDR: next_st.enablesA = wrByte;
                ENABLES_B_ADDR: next_st.enablesB = wrByte & ENABLES_B_IMPL;
                GATE_CTRL_ADDR: begin
                    next_st.globalGate = wrByte[GATE_GLOBAL_BIT];
                    next_st.periphGate = wrByte[GATE_PERIPH_BIT];
                end
                IRQ_MASK_ADDR: next_st.irqMask = wrByte[1:0];
                default: ;
            endcase
        end
        // Write one to clear; a new event in the same cycle wins
        if (wrAccess && paddr == IRQ_STATUS_ADDR) begin
            next_st.irqStatus = st.irqStatus & ~wrByte[1:0];
        end
        if (reqAny) begin
            next_st.irqStatus[IRQ_STAT_REQ_BIT] = 1'b1;
        end
        if (coreAny) begin
            next_st.irqStatus[IRQ_STAT_CORE_BIT] = 1'b1;
        end
        if (setup) begin
            next_st.errFlag = ~hit;
        end
        if (rdAccess) begin
            case (paddr)
                FLAGS_A_ADDR: next_st.rdata = {24'h0, st.flagsA};
                FLAGS_B_ADDR: next_st.rdata = {24'h0, st.flagsB};
                ENABLES_A_ADDR: next_st.rdata = {24'h0, st.enablesA};
                ENABLES_B_ADDR: next_st.rdata = {24'h0, st.enablesB};
                GATE_CTRL_ADDR: next_st.rdata = {29'h0, st.prioMode,
                                                 st.periphGate, st.globalGate};
                IRQ_STATUS_ADDR: next_st.rdata = {30'h0, st.irqStatus};
                IRQ_MASK_ADDR: next_st.rdata = {30'h0, st.irqMask};
                default: next_st.rdata = READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st.flagsA <= FLAGS_RESET;
            st.flagsB <= FLAGS_RESET;
            st.enablesA <= ENABLES_RESET;
            st.enablesB <= ENABLES_RESET;
            st.globalGate <= GATE_RESET[GATE_GLOBAL_BIT];
            st.periphGate <= GATE_RESET[GATE_PERIPH_BIT];
            st.prioMode <= GATE_RESET[GATE_PRIO_BIT];
            st.irqStatus <= IRQ_RESET;
            st.irqMask <= IRQ_RESET;
            st.rdata <= READ_ZERO;
            st.errFlag <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Read data is captured in setup, so every access completes in one cycle
    assign pready = 1'b1;
    assign pslverr = access & st.errFlag;
    assign prdata = st.rdata;
    assign periphRequest = reqAny;
    assign coreRequest = coreAny;
    assign irq = |(st.irqStatus & st.irqMask);

endmodule : pirqfe_periph_irq
`default_nettype wire

// ===== tb/pirqfe_checker_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module pirqfe_checker
    import pirqfe_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic [7:0] eventsA,
    input wire logic [7:0] eventsB,
    input wire logic priorityModeIn,
    input wire logic rxBufferFull,
    input wire logic txBufferEmpty,
    input wire logic periphRequest,
    input wire logic coreRequest,
    input wire logic irq
);
    logic wrAcc;
    assign wrAcc = psel && penable && pwrite;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    sequence s_rd;
        psel && penable && !pwrite;
    endsequence
    a_upper_zero: assert property (s_rd |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_b_unimpl: assert property (
        s_rd ##0 (paddr == FLAGS_B_ADDR || paddr == ENABLES_B_ADDR) |-> prdata[7:5] == 3'h0)
        else $error("unimplemented bits read one");
    a_bad_addr: assert property (s_rd ##0 paddr > IRQ_MASK_ADDR |-> pslverr && !prdata)
        else $error("unmapped read not refused");
    a_rx_mirror: assert property (
        s_rd ##0 (paddr == FLAGS_A_ADDR && !$past(srst, 2))
        |-> prdata[5:4] == {$past(rxBufferFull, 2), $past(txBufferEmpty, 2)})
        else $error("serial flags wrong");
    a_req_rise: assert property ($rose(periphRequest)
        |-> $past(|{eventsA, eventsB, rxBufferFull, txBufferEmpty, wrAcc}))
        else $error("request without cause");
    a_req_drop: assert property ($fell(periphRequest)
        |-> $past(wrAcc || srst || !rxBufferFull || !txBufferEmpty))
        else $error("request dropped by itself");
    a_core_gated: assert property (coreRequest |-> periphRequest)
        else $error("core request without request");
    a_core_cause: assert property ($changed(coreRequest) && $stable(periphRequest)
        |-> $past(wrAcc || srst) || $past(priorityModeIn) != $past(priorityModeIn, 2))
        else $error("core request moved alone");
    a_irq_drop: assert property ($fell(irq) |-> $past(wrAcc || srst))
        else $error("irq dropped by itself");
endmodule : pirqfe_checker
bind pirqfe_periph_irq pirqfe_checker u_chk (.mclk, .srst, .psel, .penable, .pwrite, .paddr,
    .prdata, .pslverr, .eventsA, .eventsB, .priorityModeIn, .rxBufferFull, .txBufferEmpty,
    .periphRequest, .coreRequest, .irq);
`default_nettype wire

// ===== tb/pirqfe_src_model.sv
`timescale 1ns/1ns
`default_nettype none
module pirqfe_src_model (
    input wire logic mclk,
    input wire logic [15:0] fire,
    output logic [7:0] eventsA,
    output logic [7:0] eventsB
);
    // Small package: no parallel port, so that source never fires
    always_ff @(posedge mclk) begin
        {eventsB, eventsA} <= fire & 16'hff7f;
    end
endmodule : pirqfe_src_model
`default_nettype wire

// ===== tb/test_peripheral_irq_flag_enable.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
    $display("BAD %0t got %h want %h", $time, a, e); end end
module test_peripheral_irq_flag_enable import pirqfe_pkg::*;;
    logic mclk, srst, psel, penable, pwrite, pready, pslverr, err, priorityModeIn;
    logic rxBufferFull, txBufferEmpty, periphRequest, coreRequest, irq;
    logic [7:0] paddr, eventsA, eventsB;
    logic [31:0] pwdata, prdata, rdv;
    logic [15:0] fire;
    int fail_count, total_checks;
    pirqfe_periph_irq i_pirqfe_periph_irq (.mclk, .srst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .eventsA, .eventsB, .priorityModeIn,
        .rxBufferFull, .txBufferEmpty, .periphRequest, .coreRequest, .irq);
    pirqfe_src_model i_pirqfe_src_model (.mclk, .fire, .eventsA, .eventsB);
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : xfer
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(rdv, {24'h0, e})
        `CHK(err, a > IRQ_MASK_ADDR)
    endtask : rd
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        repeat (3000) @(posedge mclk);
        fail_count++;
        results();
    end
    initial begin
        srst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, fire} = '0;
        {priorityModeIn, rxBufferFull, txBufferEmpty} = '0;
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        for (int a = 0; a < 36; a += 4) rd(8'(a), 8'h00);
        fire <= 16'hffff;
        @(posedge mclk);
        fire <= 16'h0;
        @(posedge mclk);
        rd(FLAGS_A_ADDR, 8'h4f);
        rd(FLAGS_B_ADDR, 8'h1f);
        `CHK(periphRequest, 1'b0)
        for (int i = 0; i < 16; i++) begin
            xfer(1'b1, i < 8 ? ENABLES_A_ADDR : ENABLES_B_ADDR, 32'(1 << (i % 8)));
            `CHK(periphRequest, 16'h1f4f >> i & 16'h1)
        end
        xfer(1'b1, ENABLES_B_ADDR, 32'hff);
        rd(ENABLES_B_ADDR, 8'h1f);
        xfer(1'b1, ENABLES_B_ADDR, 32'h0);
        xfer(1'b1, ENABLES_A_ADDR, 32'h4);
        `CHK(coreRequest, 1'b0)
        xfer(1'b1, GATE_CTRL_ADDR, 32'h3);
        `CHK(coreRequest, 1'b1)
        xfer(1'b1, GATE_CTRL_ADDR, 32'h1);
        `CHK(coreRequest, 1'b0)
        priorityModeIn <= 1'b1;
        repeat (2) @(posedge mclk);
        `CHK(coreRequest, 1'b1)
        rd(GATE_CTRL_ADDR, 8'h5);
        priorityModeIn <= 1'b0;
        xfer(1'b1, ENABLES_A_ADDR, 32'h0);
        `CHK(periphRequest, 1'b0)
        xfer(1'b1, FLAGS_A_ADDR, 32'hfe);
        rd(FLAGS_A_ADDR, 8'h4e);
        {rxBufferFull, txBufferEmpty} <= 2'b11;
        xfer(1'b1, FLAGS_A_ADDR, 32'h0);
        rd(FLAGS_A_ADDR, 8'h30);
        xfer(1'b1, ENABLES_A_ADDR, 32'h10);
        xfer(1'b1, IRQ_MASK_ADDR, 32'h1);
        `CHK(irq, 1'b1)
        xfer(1'b1, IRQ_MASK_ADDR, 32'h0);
        `CHK(irq, 1'b0)
        {rxBufferFull, txBufferEmpty} <= 2'b00;
        rd(IRQ_STATUS_ADDR, 8'h3);
        xfer(1'b1, IRQ_STATUS_ADDR, 32'h3);
        xfer(1'b1, IRQ_MASK_ADDR, 32'h3);
        `CHK(irq, 1'b0)
        results();
    end
endmodule : test_peripheral_irq_flag_enable
`default_nettype wire
